// ==== common/dmr_pkg.sv ====
// Constants for the mode-register and DLL-off control block of the memory device.
// Assumes a single 100 MHz command clock; command pins sampled on its rising edge.
package dmr_pkg;
    localparam int  ADDR_W        = 14;
    localparam int  BA_W          = 3;
    localparam int  DATA_W        = 8;
    // Mode register selects on bank address
    localparam logic [2:0] BA_MR0 = 3'h0;
    localparam logic [2:0] BA_MR1 = 3'h1;
    localparam logic [2:0] BA_MR2 = 3'h2;
    localparam logic [2:0] BA_MR3 = 3'h3;
    // Field positions
    localparam int  MR0_DLL_RESET = 8;
    localparam int  MR1_DLL_OFF   = 0;
    localparam int  MR2_ASR       = 6;
    localparam int  MR2_SRT       = 7;
    localparam int  MR2_RTTWR_LO  = 9;
    localparam int  MR2_RTTWR_HI  = 10;
    localparam int  MR2_CWL_LO    = 3;
    localparam int  MR2_CWL_HI    = 5;
    localparam int  MR0_CL_LO     = 4;
    localparam int  MR0_CL_HI     = 6;
    localparam int  MR1_AL_LO     = 3;
    localparam int  MR1_AL_HI     = 4;
    localparam int  MR1_WLEVEL    = 7;
    localparam int  MR3_MPR_EN    = 2;
    localparam int  MR3_MPR_LO    = 0;
    localparam int  MR3_MPR_HI    = 1;
    // Reset values
    localparam logic [13:0] MR_RESET_VAL = 14'h0000;
    // DLL-off supported latency
    localparam logic [3:0] DLLOFF_CL  = 4'h6;
    localparam logic [3:0] DLLOFF_CWL = 4'h6;
    // Encoded CL field value for CL=6 and CWL field value for CWL=6
    localparam logic [2:0] CL6_CODE   = 3'h2;
    localparam logic [2:0] CWL6_CODE  = 3'h1;
    localparam logic [3:0] CL_BASE    = 4'h4;
    localparam logic [3:0] CWL_BASE   = 4'h5;
    // Calibration readout pattern, alternating bits
    localparam logic [7:0] CAL_PATTERN = 8'h55;
    // DLL reset pulse duration
    localparam int  DLL_RST_NS    = 20;
    localparam int  CLK_PERIOD_NS = 10;
    localparam int  DLL_RST_CYC   = (DLL_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] DLL_RST_CYC_W = 8'(DLL_RST_CYC);
    typedef enum logic [4:0] {
        DMR_CMD_IDLE  = 5'h01,
        DMR_CMD_MRS   = 5'h02,
        DMR_CMD_READ  = 5'h04,
        DMR_CMD_OTHER = 5'h08,
        DMR_CMD_DESEL = 5'h10
    } dmr_cmd_t;
endpackage

// ==== dv/dmr_ctrl_model.sv ====
// Controller model: drives command, bank and address pins and self-refresh state.
// Assumes the device samples on the rising edge; this model drives on the falling edge.
`timescale 1ns/10ps
module dmr_ctrl_model #(
    parameter int T_MOD  = 12,
    parameter int T_MRD  = 4,
    parameter int T_DLLK = 16
) (
    input  wire logic   i_sys_clk,
    output logic [3:0]  o_cmd_n,
    output logic [2:0]  o_ba,
    output logic [13:0] o_addr,
    output logic        o_sr
);
    initial
    begin
        o_cmd_n = 4'hf;
        o_ba    = 3'h0;
        o_addr  = 14'h0000;
        o_sr    = 1'b0;
    end
    // Released lines take inverted values, with chip select held high, so stale data never looks valid
    task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
        @(negedge i_sys_clk);
        o_cmd_n = c;
        o_ba    = b;
        o_addr  = a;
        @(negedge i_sys_clk);
        o_cmd_n = {1'b1, ~c[2:0]};
        o_ba    = ~b;
        o_addr  = ~a;
    endtask
    task automatic mrs(input logic [2:0] b, input logic [13:0] a);
        issue(4'h0, b, (b == 3'h3) ? (a & 14'h0007) : a);
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask
    // Self-refresh stay, then the exit wait before any mode write
    task automatic sr(input int n);
        @(negedge i_sys_clk);
        o_sr = 1'b1;
        idle(n);
        o_sr = 1'b0;
        idle(T_MOD);
    endtask
    // Clock stays at 100 MHz throughout, under the DLL-off ceiling
    task automatic dll_off(input logic [13:0] m0, input logic [13:0] m1, input logic [13:0] m2);
        mrs(3'h1, m1 | 14'h0001);
        idle(T_MOD);
        sr(4);
        mrs(3'h0, m0);
        mrs(3'h2, m2);
        idle(T_MOD);
    endtask
    task automatic dll_on(input logic [13:0] m0);
        sr(4);
        mrs(3'h1, 14'h0000);
        idle(T_MRD);
        mrs(3'h0, m0 | 14'h0100);
        idle(T_DLLK);
    endtask
endmodule // dmr_ctrl_model

// ==== dv/tb_dram_mode_reg_dll_off_control.sv ====
// Self-checking bench for the mode-register and DLL-off control block.
// Assumes the controller model drives the command, bank, address and self-refresh pins; the bench drives the rest on falling edges.
`timescale 1ns/10ps
module tb_dram_mode_reg_dll_off_control;
    logic        clk, rst, sr, th_ext, dll_en, dll_rst, sr_ext, lat_ok, pat_on, rd_iss, arr_cmd, dqs;
    logic [3:0]  cmd_n;
    logic [2:0]  ba;
    logic [13:0] addr, mr0, mr1, mr2, mr3;
    logic [7:0]  arr_d, rdata;
    logic [1:0]  rtt;
    int          n_fail = 0, num_checks = 0, cyc = 0, t_ri, t_dq, n_rst = 0, n_arr = 0, n_dq = 0;

    dmr_ctrl_model u_mc (.i_sys_clk(clk), .o_cmd_n(cmd_n), .o_ba(ba), .o_addr(addr), .o_sr(sr));
    dmr_mode_ctrl u_dut (.i_sys_clk(clk), .i_rst(rst), .i_cs_n(cmd_n[3]), .i_ras_n(cmd_n[2]),
        .i_cas_n(cmd_n[1]), .i_we_n(cmd_n[0]), .i_ba(ba), .i_addr(addr), .i_selfrefresh_active(sr),
        .i_thermal_extended(th_ext), .i_array_rdata(arr_d), .o_mode_register_0(mr0),
        .o_mode_register_1(mr1), .o_mode_register_2(mr2), .o_mode_register_3(mr3), .o_dll_enable(dll_en),
        .o_dll_reset(dll_rst), .o_sr_extended_rate(sr_ext), .o_rtt_wr(rtt), .o_latency_ok(lat_ok),
        .o_cal_pattern_active(pat_on), .o_read_issue(rd_iss), .o_array_cmd(arr_cmd), .o_dqs_start(dqs),
        .o_rdata(rdata));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (rd_iss === 1'b1) t_ri <= cyc;
        if (dqs === 1'b1)
        begin
            t_dq <= cyc;
            n_dq <= n_dq + 1;
        end
        if (dll_rst === 1'b1) n_rst <= n_rst + 1;
        if (arr_cmd === 1'b1) n_arr <= n_arr + 1;
    end

    task automatic chk(input string nm, input logic [13:0] exp, input logic [13:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("Counts: %0d checks, %0d mismatches", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Gap between the read-issue pulse and the strobe-start pulse
    task automatic measure(output int d);
        int k, q;
        q = n_dq;
        u_mc.issue(4'h5, 3'h0, 14'h0000);
        for (k = 0; k < 40 && n_dq == q; k++)
            @(negedge clk);
        if (n_dq == q)
        begin
            n_fail++;
            $display("ERROR dqs_start expected pulse seen none");
            report_and_stop();
        end
        d = t_dq - t_ri;
    endtask

    task automatic t_reset();
        chk("mode_registers", 14'h0000, mr0 | mr1 | mr2 | mr3);
        chk("status", 14'h000a, {10'h0, dll_en, dll_rst, lat_ok, pat_on});
        $display("t_reset done");
    endtask
    task automatic t_rate();
        logic [2:0] v;
        for (int i = 0; i < 8; i++)
        begin
            v = 3'(i);
            u_mc.mrs(3'h2, {6'h00, v[1], v[0], 6'h00});
            th_ext = v[2];
            u_mc.idle(3);
            chk("sr_extended_rate", {13'h0, v[0] ? v[2] : v[1]}, {13'h0, sr_ext});
        end
        $display("t_rate done");
    endtask
    task automatic t_rtt();
        u_mc.mrs(3'h2, 14'h0400);
        u_mc.idle(2);
        chk("rtt_wr", 14'h0002, {12'h0, rtt});
        u_mc.mrs(3'h1, 14'h0080);
        u_mc.idle(2);
        chk("rtt_wr leveling", 14'h0000, {12'h0, rtt});
        u_mc.mrs(3'h1, 14'h0000);
        $display("t_rtt done");
    endtask
    task automatic t_pattern();
        int d, a0;
        u_mc.mrs(3'h3, 14'h0003);
        u_mc.idle(2);
        chk("mode_register_3", 14'h0003, mr3);
        chk("cal_pattern_active", 14'h0000, {13'h0, pat_on});
        arr_d = 8'h3c;
        measure(d);
        chk("rdata array", 14'h003c, {6'h0, rdata});
        a0 = n_arr;
        u_mc.issue(4'h7, 3'h1, 14'h0001);
        u_mc.issue(4'h8, 3'h1, 14'h0001);
        u_mc.idle(2);
        chk("mode_register_1", 14'h0000, mr1);
        chk("array_cmd idle", 14'h0000, 14'(n_arr - a0));
        u_mc.mrs(3'h3, 14'h0004);
        measure(d);
        chk("rdata pattern", {6'h0, dmr_pkg::CAL_PATTERN}, {6'h0, rdata});
        measure(d);
        chk("rdata pattern", {6'h0, dmr_pkg::CAL_PATTERN}, {6'h0, rdata});
        u_mc.mrs(3'h3, 14'h0000);
        u_mc.idle(2);
        chk("array_cmd pattern", 14'h0000, 14'(n_arr - a0));
        chk("cal_pattern_active", 14'h0000, {13'h0, pat_on});
        $display("t_pattern done");
    endtask
    // CL code 2 gives CL 6; AL code 1 gives AL = CL - 1
    task automatic t_dll();
        int d;
        u_mc.mrs(3'h0, 14'h0020);
        u_mc.mrs(3'h1, 14'h0008);
        u_mc.idle(2);
        measure(d);
        chk("read gap dll on", 14'h000a, 14'(d));
        u_mc.dll_off(14'h0020, 14'h0008, 14'h0008);
        chk("dll_enable off", 14'h0000, {13'h0, dll_en});
        chk("latency_ok cl6", 14'h0001, {13'h0, lat_ok});
        measure(d);
        chk("read gap dll off", 14'h0009, 14'(d));
        u_mc.mrs(3'h0, 14'h0010);
        u_mc.idle(2);
        chk("latency_ok bad cl", 14'h0000, {13'h0, lat_ok});
        chk("mode_register_1", 14'h0009, mr1);
        $display("t_dll done");
    endtask
    task automatic t_dll_on();
        int r0;
        r0 = n_rst;
        u_mc.dll_on(14'h0010);
        chk("dll_enable on", 14'h0001, {13'h0, dll_en});
        chk("mode_register_0", 14'h0010, mr0);
        chk("dll_reset cycles", 14'(dmr_pkg::DLL_RST_CYC), 14'(n_rst - r0));
        $display("t_dll_on done");
    endtask

    initial
    begin
        rst    = 1'b1;
        th_ext = 1'b0;
        arr_d  = 8'ha3;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_rate();
        t_rtt();
        t_pattern();
        t_dll();
        t_dll_on();
        report_and_stop();
    end
endmodule // tb_dram_mode_reg_dll_off_control

// ==== rtl/dmr_mode_ctrl.sv ====
// Mode-register file, command decode, calibration readout and DLL-off latency handling.
// Assumes the controller obeys command ordering and timing; inputs synchronous to i_sys_clk.
`timescale 1ns/10ps
module dmr_mode_ctrl (
    input  wire logic                            i_sys_clk,
    input  wire logic                            i_rst,
    input  wire logic                            i_cs_n,
    input  wire logic                            i_ras_n,
    input  wire logic                            i_cas_n,
    input  wire logic                            i_we_n,
    input  wire logic [dmr_pkg::BA_W-1:0]        i_ba,
    input  wire logic [dmr_pkg::ADDR_W-1:0]      i_addr,
    input  wire logic                            i_selfrefresh_active,
    input  wire logic                            i_thermal_extended,
    input  wire logic [dmr_pkg::DATA_W-1:0]      i_array_rdata,
    output logic [dmr_pkg::ADDR_W-1:0]           o_mode_register_0,
    output logic [dmr_pkg::ADDR_W-1:0]           o_mode_register_1,
    output logic [dmr_pkg::ADDR_W-1:0]           o_mode_register_2,
    output logic [dmr_pkg::ADDR_W-1:0]           o_mode_register_3,
    output logic                                 o_dll_enable,
    output logic                                 o_dll_reset,
    output logic                                 o_sr_extended_rate,
    output logic [1:0]                           o_rtt_wr,
    output logic                                 o_latency_ok,
    output logic                                 o_cal_pattern_active,
    output logic                                 o_read_issue,
    output logic                                 o_array_cmd,
    output logic                                 o_dqs_start,
    output logic [dmr_pkg::DATA_W-1:0]           o_rdata
);
    localparam int LAT_W = 5;

    logic [dmr_pkg::ADDR_W-1:0] mr_q [4];
    logic [7:0]                 dll_rst_cnt_q;
    logic                       dll_rst_q;
    logic [dmr_pkg::DATA_W-1:0] rdata_q;
    logic                       read_q;
    logic                       array_cmd_q;
    logic                       sr_ext_q;
    dmr_pkg::dmr_cmd_t          cmd;
    logic [LAT_W-1:0]           rd_lat;
    logic [3:0]                 cl_val;
    logic [3:0]                 al_val;
    logic                       dll_off;
    logic                       mpr_on;

    function automatic dmr_pkg::dmr_cmd_t decode_cmd(
        input logic cs_n,
        input logic ras_n,
        input logic cas_n,
        input logic we_n
    );
        dmr_pkg::dmr_cmd_t c;
        c = dmr_pkg::DMR_CMD_OTHER;
        if (cs_n)
            c = dmr_pkg::DMR_CMD_DESEL;
        else if (ras_n && cas_n && we_n)
            c = dmr_pkg::DMR_CMD_IDLE;
        else if (!ras_n && !cas_n && !we_n)
            c = dmr_pkg::DMR_CMD_MRS;
        else if (ras_n && !cas_n && we_n)
            c = dmr_pkg::DMR_CMD_READ;
        return c;
    endfunction

    assign cmd     = decode_cmd(i_cs_n, i_ras_n, i_cas_n, i_we_n);
    assign dll_off = mr_q[1][dmr_pkg::MR1_DLL_OFF];
    assign mpr_on  = mr_q[3][dmr_pkg::MR3_MPR_EN];

    // Mode register writes; unwritten registers keep their value, except the MR0 DLL reset bit, which self-clears
    generate
        for (genvar g = 0; g < 4; g++)
        begin : g_mr
            always_ff @(posedge i_sys_clk or posedge i_rst)
            begin
                if (i_rst)
                    mr_q[g] <= dmr_pkg::MR_RESET_VAL;
                else if (cmd == dmr_pkg::DMR_CMD_MRS && i_ba == dmr_pkg::BA_W'(g))
                    mr_q[g] <= i_addr;
                else if (g == 0 && dll_rst_q && dll_rst_cnt_q == 8'h01)
                    mr_q[g][dmr_pkg::MR0_DLL_RESET] <= 1'b0;
            end
        end
    endgenerate

    // DLL reset runs for a fixed time then clears the request bit
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            dll_rst_q     <= 1'b0;
            dll_rst_cnt_q <= 8'h00;
        end
        else if (!dll_rst_q && mr_q[0][dmr_pkg::MR0_DLL_RESET])
        begin
            dll_rst_q     <= 1'b1;
            dll_rst_cnt_q <= dmr_pkg::DLL_RST_CYC_W;
        end
        else if (dll_rst_q)
        begin
            if (dll_rst_cnt_q == 8'h01)
                dll_rst_q <= 1'b0;
            dll_rst_cnt_q <= dll_rst_cnt_q - 8'h01;
        end
    end

    // Rate choice latched only outside self-refresh so it is stable within one
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            sr_ext_q <= 1'b0;
        else if (!i_selfrefresh_active)
            sr_ext_q <= mr_q[2][dmr_pkg::MR2_ASR] ? i_thermal_extended
                                                  : mr_q[2][dmr_pkg::MR2_SRT];
    end

    // Read path: pattern replaces array data while readout enabled
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rdata_q     <= '0;
            read_q      <= 1'b0;
            array_cmd_q <= 1'b0;
        end
        else
        begin
            read_q      <= (cmd == dmr_pkg::DMR_CMD_READ);
            // Idle and deselect never reach the array
            array_cmd_q <= (cmd == dmr_pkg::DMR_CMD_READ && !mpr_on) ||
                           (cmd == dmr_pkg::DMR_CMD_OTHER);
            if (cmd == dmr_pkg::DMR_CMD_READ)
            begin
                if (mpr_on)
                    rdata_q <= dmr_pkg::CAL_PATTERN;
                else
                    rdata_q <= i_array_rdata;
            end
        end
    end

    // Latency decode; AL field 3 is reserved and treated as zero
    always_comb
    begin
        cl_val = dmr_pkg::CL_BASE + {1'b0, mr_q[0][dmr_pkg::MR0_CL_HI:dmr_pkg::MR0_CL_LO]};
        case (mr_q[1][dmr_pkg::MR1_AL_HI:dmr_pkg::MR1_AL_LO])
            2'h1:    al_val = cl_val - 4'h1;
            2'h2:    al_val = cl_val - 4'h2;
            default: al_val = 4'h0;
        endcase
        rd_lat = LAT_W'(al_val) + LAT_W'(cl_val) - (dll_off ? LAT_W'(1) : LAT_W'(0));
    end

    dmr_read_lat #(
        .CNT_W (LAT_W)
    ) u_read_lat (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_start   (cmd == dmr_pkg::DMR_CMD_READ),
        .i_latency (rd_lat),
        .o_fire    (o_dqs_start)
    );

    assign o_mode_register_0    = mr_q[0];
    assign o_mode_register_1    = mr_q[1];
    assign o_mode_register_2    = mr_q[2];
    assign o_mode_register_3    = mr_q[3];
    assign o_dll_enable         = !dll_off;
    assign o_dll_reset          = dll_rst_q;
    assign o_sr_extended_rate   = sr_ext_q;
    // Dynamic termination withheld in write leveling
    assign o_rtt_wr             = mr_q[1][dmr_pkg::MR1_WLEVEL] ? 2'h0
                                : mr_q[2][dmr_pkg::MR2_RTTWR_HI:dmr_pkg::MR2_RTTWR_LO];
    // DLL-off only guarantees the single latency pair
    assign o_latency_ok         = !dll_off ||
                                  (mr_q[0][dmr_pkg::MR0_CL_HI:dmr_pkg::MR0_CL_LO] == dmr_pkg::CL6_CODE &&
                                   mr_q[2][dmr_pkg::MR2_CWL_HI:dmr_pkg::MR2_CWL_LO] == dmr_pkg::CWL6_CODE);
    assign o_cal_pattern_active = mpr_on;
    assign o_read_issue         = read_q;
    assign o_array_cmd          = array_cmd_q;
    assign o_rdata              = rdata_q;

    // Assertions
    sequence mr1_write_seq;
        cmd == dmr_pkg::DMR_CMD_MRS && i_ba == dmr_pkg::BA_MR1;
    endsequence

    sequence mr3_write_seq;
        cmd == dmr_pkg::DMR_CMD_MRS && i_ba == dmr_pkg::BA_MR3;
    endsequence

    mr_write_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        mr3_write_seq |=> mr_q[3] == $past(i_addr))
        else $error("mode register 3 write lost");

    mr_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (cmd != dmr_pkg::DMR_CMD_MRS) |=> mr_q[2] == $past(mr_q[2]))
        else $error("mode register 2 changed without write");

    mr1_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (cmd != dmr_pkg::DMR_CMD_MRS) |=> mr_q[1] == $past(mr_q[1]))
        else $error("mode register 1 changed without write");

    cal_read_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (cmd == dmr_pkg::DMR_CMD_READ && mpr_on)
            |=> (rdata_q == dmr_pkg::CAL_PATTERN && !array_cmd_q))
        else $error("read not redirected to pattern");

    pattern_sel_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (cmd == dmr_pkg::DMR_CMD_READ && !mpr_on)
            |=> rdata_q == $past(i_array_rdata))
        else $error("pattern used while readout disabled");

    nop_quiet_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (cmd == dmr_pkg::DMR_CMD_IDLE) |=> !array_cmd_q && !read_q)
        else $error("no-operation started a command");

    desel_quiet_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_cs_n |=> !array_cmd_q && !read_q && mr_q[1] == $past(mr_q[1]))
        else $error("deselected device acted");

    dll_off_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        mr1_write_seq |=> o_dll_enable == !$past(i_addr[dmr_pkg::MR1_DLL_OFF]))
        else $error("DLL enable disagrees with mode register 1 write");

    // Only valid with one read in flight; a later read restarts the timer
    sequence rd_off_seq;
        cmd == dmr_pkg::DMR_CMD_READ && dll_off && rd_lat == LAT_W'(10);
    endsequence

    sequence rd_on_seq;
        cmd == dmr_pkg::DMR_CMD_READ && !dll_off && rd_lat == LAT_W'(11);
    endsequence

    dqs_offlat_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        rd_off_seq |-> ##10 o_dqs_start)
        else $error("DLL-off strobe latency wrong");

    dqs_onlat_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        rd_on_seq |-> ##11 o_dqs_start)
        else $error("DLL-on strobe latency wrong");

    sequence rst_set_seq;
        !dll_rst_q && mr_q[0][dmr_pkg::MR0_DLL_RESET];
    endsequence

    dll_selfclr_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        rst_set_seq |-> ##[1:3] !mr_q[0][dmr_pkg::MR0_DLL_RESET])
        else $error("DLL reset bit did not clear");

    // Window length follows the two-cycle reset time
    dll_rst_len_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        $rose(dll_rst_q) |-> dll_rst_q [*2] ##1 !dll_rst_q)
        else $error("DLL reset window length wrong");

    sr_rate_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (!i_selfrefresh_active && !mr_q[2][dmr_pkg::MR2_ASR])
            |=> sr_ext_q == $past(mr_q[2][dmr_pkg::MR2_SRT]))
        else $error("manual rate not taken from range bit");

    auto_rate_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (!i_selfrefresh_active && mr_q[2][dmr_pkg::MR2_ASR])
            |=> sr_ext_q == $past(i_thermal_extended))
        else $error("auto rate not taken from thermal sensor");

    // Rate must not move while the array is refreshing itself
    sr_freeze_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_selfrefresh_active |=> sr_ext_q == $past(sr_ext_q))
        else $error("refresh rate changed inside self-refresh");

    rtt_level_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        mr_q[1][dmr_pkg::MR1_WLEVEL] |-> o_rtt_wr == 2'h0)
        else $error("dynamic termination active in write leveling");
endmodule // dmr_mode_ctrl

// ==== rtl/dmr_read_lat.sv ====
// Read latency timer: issues the strobe-start pulse a programmed number of cycles after a read.
// Assumes reads spaced so at most one is in flight within the latency window.
`timescale 1ns/10ps
module dmr_read_lat #(
    parameter int CNT_W = 5
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_rst,
    input  wire logic             i_start,
    input  wire logic [CNT_W-1:0] i_latency,
    output logic                  o_fire
);
    logic [CNT_W-1:0] cnt_q;
    logic             busy_q;
    logic             fire_q;

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cnt_q  <= '0;
            busy_q <= 1'b0;
            fire_q <= 1'b0;
        end
        else
        begin
            fire_q <= 1'b0;
            if (i_start)
            begin
                // Latency of one fires on the next edge
                if (i_latency <= CNT_W'(1))
                begin
                    fire_q <= 1'b1;
                    busy_q <= 1'b0;
                end
                else
                begin
                    cnt_q  <= i_latency - CNT_W'(1);
                    busy_q <= 1'b1;
                end
            end
            else if (busy_q)
            begin
                if (cnt_q == CNT_W'(1))
                begin
                    fire_q <= 1'b1;
                    busy_q <= 1'b0;
                end
                else
                begin
                    cnt_q <= cnt_q - CNT_W'(1);
                end
            end
        end
    end

    assign o_fire = fire_q;
endmodule // dmr_read_lat
